// ### mmd_pkg.sv
// Package of constants and types for the memory map decoder
// Overview of operation
// - Reads of undefined special function register addresses return zero.
// - Flash split comes from two-bit configuration field; 11 is all program.
// - 4 kB part: 00,01 give 2/2; 10 gives 3/1; 11 gives 4/0.
// - 8 kB part: 00 gives 4/4; 01 6/2; 10 7/1; 11 8/0.
// - Program region starts at zero and shrinks from its top.
// - Data flash appears in data space from 0400 hex upward.
// - Instruction fetch only from the program region, never data flash.
// - Lock option blocks erase/write of lowest 4 kB or whole program flash.
// - Data flash stays fully accessible while program flash is locked.
// - Write-target select bit steers data-space writes to program or data.
// - Flash uses 64-byte pages; a page is erased before writing.
// - Configuration registers are writable only in flash programming mode.
// - Direct addresses 0-127 are RAM, 128-255 are special registers.
// - RAM bytes 20-2F hex give 128 bit-addressable bits.
// - Only registers with low nibble 0 or 8 are bit addressable.
// - Bit versus byte access is decided by instruction type.
// - Four banks of eight working registers chosen by status word field.
// - Program memory is fetched automatically and readable by code reads.
package mmd_pkg;
    // ****************************************************************
    // Address constants
    // ****************************************************************
    localparam logic [15:0] MMD_DATA_BASE    = 16'h0400;
    localparam logic [15:0] MMD_KB           = 16'h0400;
    localparam logic [15:0] MMD_LOCK_LOW_TOP = 16'h1000;
    localparam logic [7:0]  MMD_STATUS_ADDR  = 8'hD0;
    localparam logic [7:0]  MMD_WSEL_ADDR    = 8'h8F;
    localparam logic [7:0]  MMD_BIT_RAM_BASE = 8'h20;
    localparam logic [7:0]  MMD_SFR_BASE     = 8'h80;
    localparam logic [7:0]  MMD_STATUS_RESET = 8'h00;
    localparam logic [7:0]  MMD_WSEL_RESET   = 8'h00;
    localparam logic [1:0]  MMD_SPLIT_RESET  = 2'h3;
    localparam int          MMD_BANK_LSB     = 3;
    localparam int          MMD_WSEL_BIT     = 0;
    localparam int          MMD_PAGE_BITS    = 6;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        MMD_LOCK_NONE,
        MMD_LOCK_LOW,
        MMD_LOCK_ALL
    } mmd_lock_e;

    typedef struct packed {
        logic [15:0] prog_top;
        logic [15:0] data_size;
    } mmd_split_s;

    typedef struct packed {
        logic        bit_op;
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } mmd_dir_s;
endpackage

// ### mmd_split.sv
// Flash partition table: program top and data size per split code
`timescale 1ns/1ps
module mmd_split #(
    parameter bit BIG = 1'b1
) (
    input  wire logic [1:0]          code,
    output mmd_pkg::mmd_split_s      split
);
    import mmd_pkg::*;

    logic [3:0] prog_kb;

    // ****************************************************************
    // Table
    // ****************************************************************
    always_comb begin
        unique case (code)
            2'h0:    prog_kb = BIG ? 4'h4 : 4'h2;
            2'h1:    prog_kb = BIG ? 4'h6 : 4'h2;
            2'h2:    prog_kb = BIG ? 4'h7 : 4'h3;
            default: prog_kb = BIG ? 4'h8 : 4'h4;
        endcase
    end

    // Program always starts at zero; data takes what is cut off the top
    assign split.prog_top  = 16'(prog_kb) * MMD_KB;
    assign split.data_size = 16'((BIG ? 4'h8 : 4'h4) - prog_kb) * MMD_KB;
endmodule

// ### mmd_sram.sv
// Scratchpad RAM with byte and bit access
`timescale 1ns/1ps
module mmd_sram #(
    parameter int DEPTH = 128
) (
    input  wire logic       clk_sys,
    input  wire logic       we,
    input  wire logic [6:0] addr,
    input  wire logic [7:0] wmask,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);
    import mmd_pkg::*;

    logic [7:0] mem_q [DEPTH];

    // Masked write lets one bit change without a read-modify-write bus
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem_q[addr] <= (mem_q[addr] & ~wmask) | (wdata & wmask);
        end
    end

    assign rdata = mem_q[addr];
endmodule

// ### mmd_top.sv
// Memory map decoder: flash split, data space, direct space and banks
`timescale 1ns/1ps
module mmd_top #(
    parameter bit BIG = 1'b1
) (
    input  wire logic                clk_sys,
    input  wire logic                srst,
    input  wire logic                prog_mode,
    input  wire logic                cfg_wr,
    input  wire logic [1:0]          cfg_split,
    input  wire logic [1:0]          cfg_lock,
    input  wire logic [15:0]         fetch_addr,
    input  wire logic                fetch_req,
    input  wire logic [15:0]         code_rd_addr,
    input  wire logic                code_rd_req,
    input  wire logic [15:0]         xaddr,
    input  wire logic                xrd,
    input  wire logic                xwr,
    input  wire logic                xerase,
    input  wire mmd_pkg::mmd_dir_s   dir,
    input  wire logic [2:0]          wreg_sel,
    input  wire logic                wreg_op,
    input  wire logic [7:0]          sfr_ext_rdata,
    input  wire logic                sfr_ext_hit,
    output logic [1:0]               split_code,
    output logic                     fetch_ok,
    output logic                     fetch_fault,
    output logic [15:0]              code_flash_addr,
    output logic                     code_flash_rd,
    output logic                     flash_sel,
    output logic                     flash_wr,
    output logic                     flash_erase,
    output logic                     flash_to_program,
    output logic [15:0]              flash_addr,
    output logic [15:0]              page_base,
    output logic                     ext_sel,
    output logic                     access_denied,
    output logic                     sfr_sel,
    output logic                     sfr_wr,
    output logic [7:0]               sfr_addr,
    output logic [7:0]               dir_rdata,
    output logic [1:0]               bank_q
);
    import mmd_pkg::*;

    // ****************************************************************
    // Configuration bytes
    // ****************************************************************
    logic [1:0] split_q;
    logic [1:0] lock_q;
    logic [7:0] status_q;
    logic [7:0] wsel_q;
    mmd_split_s split;

    // Configuration is held across srst only by being reloaded by loader
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            split_q <= MMD_SPLIT_RESET;
            lock_q  <= 2'h0;
        end else if (cfg_wr && prog_mode) begin
            split_q <= cfg_split;
            lock_q  <= cfg_lock;
        end
    end

    assign split_code = split_q;

    mmd_split #(
        .BIG   (BIG)
    ) u_split (
        .code  (split_q),
        .split (split)
    );

    mmd_lock_e lock_mode;
    always_comb begin
        unique case (lock_q)
            2'h1:    lock_mode = MMD_LOCK_LOW;
            2'h2:    lock_mode = MMD_LOCK_ALL;
            2'h3:    lock_mode = MMD_LOCK_ALL;
            default: lock_mode = MMD_LOCK_NONE;
        endcase
    end

    // ****************************************************************
    // Program fetch and code reads
    // ****************************************************************
    logic fetch_in_prog;
    assign fetch_in_prog = fetch_addr < split.prog_top;
    assign fetch_ok      = fetch_req && fetch_in_prog;
    assign fetch_fault   = fetch_req && !fetch_in_prog;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            code_flash_addr <= 16'h0000;
            code_flash_rd   <= 1'b0;
        end else begin
            code_flash_rd <= code_rd_req &&
                             (code_rd_addr < split.prog_top);
            if (code_rd_req) begin
                code_flash_addr <= code_rd_addr;
            end
        end
    end

    // ****************************************************************
    // Data-space moves
    // ****************************************************************
    logic        to_prog;
    logic        in_data;
    logic        in_prog;
    logic [15:0] data_off;
    logic [15:0] tgt;
    logic        locked;
    logic        any;

    assign to_prog  = wsel_q[MMD_WSEL_BIT];
    assign data_off = 16'(xaddr - MMD_DATA_BASE);
    assign in_data  = (xaddr >= MMD_DATA_BASE) &&
                      (data_off < split.data_size);
    assign in_prog  = xaddr < split.prog_top;
    // Data flash sits physically above the program region
    assign tgt      = to_prog ? xaddr : 16'(split.prog_top + data_off);
    assign any     = xrd || xwr || xerase;

    always_comb begin
        locked = 1'b0;
        if (to_prog && (xwr || xerase)) begin
            unique case (lock_mode)
                MMD_LOCK_LOW:  locked = xaddr < MMD_LOCK_LOW_TOP;
                MMD_LOCK_ALL:  locked = 1'b1;
                MMD_LOCK_NONE: locked = 1'b0;
            endcase
            if (prog_mode) begin
                locked = 1'b0;
            end
        end
    end

    logic hit;
    // Only an unlocked hit reaches flash; a miss goes to external space, a locked hit to neither
    assign hit = to_prog ? in_prog : in_data;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flash_sel        <= 1'b0;
            flash_wr         <= 1'b0;
            flash_erase      <= 1'b0;
            flash_to_program <= 1'b0;
            flash_addr       <= 16'h0000;
            page_base        <= 16'h0000;
            ext_sel          <= 1'b0;
            access_denied    <= 1'b0;
        end else begin
            flash_sel        <= any && hit && !locked;
            flash_wr         <= xwr && hit && !locked;
            flash_erase      <= xerase && hit && !locked;
            flash_to_program <= to_prog;
            flash_addr       <= tgt;
            // Erase acts on the whole 64-byte page
            page_base        <= {tgt[15:MMD_PAGE_BITS],
                                 MMD_PAGE_BITS'(0)};
            ext_sel          <= any && !hit;
            access_denied    <= any && hit && locked;
        end
    end

    // ****************************************************************
    // Direct space
    // ****************************************************************
    logic       is_sfr;
    logic [2:0] bit_idx;
    logic [7:0] byte_addr;
    logic [7:0] wmask;
    logic [7:0] ram_rdata;
    logic [7:0] sfr_rd;
    logic       ram_we;
    logic [6:0] ram_addr;

    // For bit operations the direct address names a bit, not a byte
    always_comb begin
        bit_idx   = dir.addr[2:0];
        byte_addr = dir.addr;
        if (dir.bit_op) begin
            if (dir.addr[7]) begin
                byte_addr = {dir.addr[7:3], 3'h0};
            end else begin
                byte_addr = 8'(MMD_BIT_RAM_BASE + 8'(dir.addr[6:3]));
            end
        end
    end

    assign is_sfr = byte_addr >= MMD_SFR_BASE;
    assign wmask  = dir.bit_op ? (8'h01 << bit_idx) : 8'hFF;

    always_comb begin
        ram_addr = byte_addr[6:0];
        if (wreg_op) begin
            ram_addr = {2'h0, bank_q, wreg_sel};
        end
    end
    assign ram_we = wreg_op ? dir.wr : (dir.wr && !is_sfr);

    mmd_sram #(
        .DEPTH (128)
    ) u_ram (
        .clk_sys (clk_sys),
        .we      (ram_we),
        .addr    (ram_addr),
        .wmask   (wmask),
        .wdata   (dir.bit_op ? {8{dir.wdata[0]}} : dir.wdata),
        .rdata   (ram_rdata)
    );

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status_q <= MMD_STATUS_RESET;
            wsel_q   <= MMD_WSEL_RESET;
        end else if (dir.wr && is_sfr && !wreg_op) begin
            if (byte_addr == MMD_STATUS_ADDR) begin
                status_q <= (status_q & ~wmask) | (dir.bit_op ?
                            {8{dir.wdata[0]}} & wmask : dir.wdata & wmask);
            end
            // Its address is not bit addressable, so bit writes miss it
            if (byte_addr == MMD_WSEL_ADDR && !dir.bit_op) begin
                wsel_q <= dir.wdata;
            end
        end
    end

    assign bank_q = status_q[MMD_BANK_LSB +: 2];

    always_comb begin
        if (byte_addr == MMD_STATUS_ADDR) begin
            sfr_rd = status_q;
        end else if (byte_addr == MMD_WSEL_ADDR) begin
            sfr_rd = wsel_q;
        end else if (sfr_ext_hit) begin
            sfr_rd = sfr_ext_rdata;
        end else begin
            sfr_rd = 8'h00;
        end
    end

    assign sfr_sel  = (dir.rd || dir.wr) && is_sfr && !wreg_op;
    assign sfr_wr   = dir.wr && is_sfr && !wreg_op;
    assign sfr_addr = byte_addr;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dir_rdata <= 8'h00;
        end else if (dir.rd || wreg_op) begin
            if (!wreg_op && is_sfr) begin
                dir_rdata <= dir.bit_op ? 8'(sfr_rd[bit_idx]) : sfr_rd;
            end else begin
                dir_rdata <= dir.bit_op ? 8'(ram_rdata[bit_idx]) : ram_rdata;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Each property repeats its clock so it stands on its own
    chk_undef_sfr_zero: assert property (
        @(posedge clk_sys) disable iff (srst)
        dir.rd && !dir.bit_op && !wreg_op && is_sfr && !sfr_ext_hit &&
        byte_addr != MMD_STATUS_ADDR && byte_addr != MMD_WSEL_ADDR
        |=> dir_rdata == 8'h00)
        else $error("undefined register read not zero");
    chk_reset_split: assert property (
        @(posedge clk_sys)
        srst |=> split_q == MMD_SPLIT_RESET)
        else $error("split not default after reset");
    chk_cfg_locked_out: assert property (
        @(posedge clk_sys) disable iff (srst)
        !prog_mode |=> $stable(split_q))
        else $error("configuration changed outside programming");
    chk_cfg_load: assert property (
        @(posedge clk_sys) disable iff (srst)
        cfg_wr && prog_mode |=> split_q == $past(cfg_split))
        else $error("configuration not loaded in programming");
    chk_fetch_region: assert property (
        @(posedge clk_sys) disable iff (srst)
        fetch_ok |-> fetch_addr < split.prog_top)
        else $error("fetch outside program region");
    chk_fetch_fault: assert property (
        @(posedge clk_sys) disable iff (srst)
        fetch_req && fetch_addr >= split.prog_top |-> fetch_fault && !fetch_ok)
        else $error("fetch above program region not refused");
    chk_code_read: assert property (
        @(posedge clk_sys) disable iff (srst)
        code_rd_req && code_rd_addr >= split.prog_top |=> !code_flash_rd)
        else $error("code read above program region");
    chk_split_total: assert property (
        @(posedge clk_sys) disable iff (srst)
        split.prog_top + split.data_size == 16'(BIG ? 8 : 4) * MMD_KB)
        else $error("partition does not cover flash");
    chk_lock_all: assert property (
        @(posedge clk_sys) disable iff (srst)
        xwr && to_prog && !prog_mode && lock_mode == MMD_LOCK_ALL
        |=> !flash_wr && access_denied == $past(in_prog))
        else $error("locked program write reached flash");
    chk_lock_bypass: assert property (
        @(posedge clk_sys) disable iff (srst)
        prog_mode && xwr && to_prog && in_prog |=> flash_wr && !access_denied)
        else $error("programming write blocked by lock");
    chk_data_free: assert property (
        @(posedge clk_sys) disable iff (srst)
        xwr && !to_prog && in_data |=> flash_wr && !access_denied)
        else $error("data flash write blocked");
    chk_data_window: assert property (
        @(posedge clk_sys) disable iff (srst)
        xrd && !to_prog && in_data |=> flash_sel && !ext_sel)
        else $error("data window read missed flash");
    chk_ext_forward: assert property (
        @(posedge clk_sys) disable iff (srst)
        xrd && !to_prog && xaddr < MMD_DATA_BASE |=> ext_sel && !flash_sel)
        else $error("low data address reached flash");
    chk_page_align: assert property (
        @(posedge clk_sys) disable iff (srst)
        flash_erase |-> page_base[MMD_PAGE_BITS-1:0] == '0)
        else $error("erase page not aligned");
    chk_sfr_split: assert property (
        @(posedge clk_sys) disable iff (srst)
        dir.rd && !dir.bit_op && !wreg_op |-> sfr_sel == dir.addr[7])
        else $error("direct decode wrong");
    chk_bit_mask: assert property (
        @(posedge clk_sys) disable iff (srst)
        dir.bit_op |-> $onehot(wmask))
        else $error("bit access touches more than one bit");
    chk_bit_ram: assert property (
        @(posedge clk_sys) disable iff (srst)
        dir.bit_op && !dir.addr[7] |-> byte_addr[7:4] == 4'h2)
        else $error("RAM bit outside bit area");
    chk_bit_sfr: assert property (
        @(posedge clk_sys) disable iff (srst)
        dir.bit_op && dir.addr[7] |-> byte_addr[2:0] == 3'h0)
        else $error("register bit on a byte not bit addressable");
    chk_wreg_no_sfr: assert property (
        @(posedge clk_sys) disable iff (srst)
        wreg_op |-> !sfr_sel && !sfr_wr)
        else $error("working register access reached registers");
    chk_reset_status: assert property (
        @(posedge clk_sys)
        srst |=> status_q == MMD_STATUS_RESET && wsel_q == MMD_WSEL_RESET)
        else $error("status or write select not cleared by reset");
endmodule

// ### mmd_sfr_model.sv
// Model of the other special function registers behind the decoder
`timescale 1ns/1ps
module mmd_sfr_model #(
    parameter logic [7:0] ADDR = 8'h90,
    parameter logic [7:0] VAL  = 8'h5A
) (
    input  wire logic       sfr_sel,
    input  wire logic [7:0] sfr_addr,
    output logic            sfr_ext_hit,
    output logic      [7:0] sfr_ext_rdata
);
    // ****************************************************************
    // Answer only for its own register
    // ****************************************************************
    // No other address answers, so undefined ones fall to the decoder
    assign sfr_ext_hit   = sfr_sel && (sfr_addr == ADDR);
    // Off-target data is inverted so that a stray pick-up shows
    assign sfr_ext_rdata = sfr_ext_hit ? VAL : ~VAL;
endmodule

// ### memory_map_decoder_tb.sv
// Testbench for the memory map decoder
`timescale 1ns/1ps
module memory_map_decoder_tb;
    import mmd_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        prog_mode = 1'b0, cfg_wr = 1'b0;
    logic [1:0]  cfg_split = 2'h0, cfg_lock = 2'h0;
    logic [15:0] fetch_addr = 16'h0000, code_rd_addr = 16'h0000;
    logic        fetch_req = 1'b0, code_rd_req = 1'b0;
    logic [15:0] xaddr = 16'h0000;
    logic        xrd = 1'b0, xwr = 1'b0, xerase = 1'b0;
    mmd_dir_s    dir = '0;
    logic [2:0]  wreg_sel = 3'h0;
    logic        wreg_op = 1'b0;
    logic [7:0]  sfr_ext_rdata, sfr_addr, dir_rdata;
    logic        sfr_ext_hit, sfr_sel, fetch_ok, fetch_fault;
    logic [1:0]  split_code, bank_q;
    logic        code_flash_rd, flash_sel, flash_wr, flash_erase;
    logic        flash_to_program, ext_sel, access_denied;
    logic [15:0] code_flash_addr, flash_addr, page_base;
    logic [15:0] top, dsz;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #4 clk_sys = ~clk_sys;

    mmd_top #(.BIG(1'b1)) dut (
        .clk_sys(clk_sys), .srst(srst), .prog_mode(prog_mode),
        .cfg_wr(cfg_wr), .cfg_split(cfg_split), .cfg_lock(cfg_lock),
        .fetch_addr(fetch_addr), .fetch_req(fetch_req),
        .code_rd_addr(code_rd_addr), .code_rd_req(code_rd_req),
        .xaddr(xaddr), .xrd(xrd), .xwr(xwr), .xerase(xerase),
        .dir(dir), .wreg_sel(wreg_sel), .wreg_op(wreg_op),
        .sfr_ext_rdata(sfr_ext_rdata), .sfr_ext_hit(sfr_ext_hit),
        .split_code(split_code), .fetch_ok(fetch_ok),
        .fetch_fault(fetch_fault), .code_flash_addr(code_flash_addr),
        .code_flash_rd(code_flash_rd), .flash_sel(flash_sel),
        .flash_wr(flash_wr), .flash_erase(flash_erase),
        .flash_to_program(flash_to_program), .flash_addr(flash_addr),
        .page_base(page_base), .ext_sel(ext_sel),
        .access_denied(access_denied), .sfr_sel(sfr_sel), .sfr_wr(),
        .sfr_addr(sfr_addr), .dir_rdata(dir_rdata), .bank_q(bank_q)
    );

    mmd_sfr_model sfrm (
        .sfr_sel(sfr_sel), .sfr_addr(sfr_addr),
        .sfr_ext_hit(sfr_ext_hit), .sfr_ext_rdata(sfr_ext_rdata)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cfg(logic pm, logic [1:0] sp, logic [1:0] lk);
        @(negedge clk_sys);
        prog_mode = pm;
        cfg_split = sp;
        cfg_lock = lk;
        cfg_wr = 1'b1;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
        prog_mode = 1'b0;
    endtask

    // Outputs stand until the next rising edge, so callers check them
    // at the falling edge where the strobe is dropped
    task automatic xacc(int k, logic [15:0] a);
        @(negedge clk_sys);
        xaddr = a;
        xrd = (k == 0);
        xwr = (k == 1);
        xerase = (k == 2);
        @(negedge clk_sys);
        {xrd, xwr, xerase} = 3'h0;
    endtask

    task automatic dacc(logic b, logic w, logic [7:0] a, logic [7:0] d,
                        logic wo = 1'b0, logic [2:0] sel = 3'h0);
        @(negedge clk_sys);
        dir = '{bit_op: b, wr: w, rd: !w, addr: a, wdata: d};
        wreg_op = wo;
        wreg_sel = sel;
        @(negedge clk_sys);
        dir = '0;
        wreg_op = 1'b0;
    endtask

    task automatic probe(logic [15:0] a);
        @(negedge clk_sys);
        fetch_addr = a;
        fetch_req = 1'b1;
        code_rd_addr = a;
        code_rd_req = 1'b1;
        @(posedge clk_sys);
        #1;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            test_done();
        end
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        chk("split reset", split_code, 16'h3);
        chk("bank reset", bank_q, 16'h0);
        for (int s = 0; s < 4; s++) begin
            top = (s == 0) ? 16'h1000 : (s == 1) ? 16'h1800 :
                  (s == 2) ? 16'h1C00 : 16'h2000;
            dsz = 16'h2000 - top;
            cfg(1'b1, s[1:0], 2'h0);
            chk("split", split_code, s);
            xacc(1, MMD_DATA_BASE);
            chk("dflash sel", flash_sel, dsz != 0);
            chk("dflash ext", ext_sel, dsz == 0);
            if (dsz != 0) chk("dflash addr", flash_addr, top);
            xacc(0, MMD_DATA_BASE + dsz);
            chk("past window", {flash_sel, ext_sel}, 16'h1);
            probe(top - 16'h1);
            chk("fetch in", {fetch_ok, fetch_fault}, 16'h2);
            @(negedge clk_sys);
            chk("crd in", code_flash_rd, 16'h1);
            probe(top);
            chk("fetch out", {fetch_ok, fetch_fault}, 16'h1);
            @(negedge clk_sys);
            chk("crd out", code_flash_rd, 16'h0);
            fetch_req = 1'b0;
            code_rd_req = 1'b0;
        end
        cfg(1'b1, 2'h0, 2'h0);
        cfg(1'b0, 2'h1, 2'h0);
        chk("cfg locked", split_code, 16'h0);
        xacc(2, 16'h0457);
        chk("erase", flash_erase, 16'h1);
        chk("page", page_base, 16'h1040);
        cfg(1'b1, 2'h3, 2'h1);
        dacc(1'b0, 1'b1, MMD_WSEL_ADDR, 8'h01);
        xacc(1, 16'h0800);
        chk("low lock", {access_denied, flash_wr}, 16'h2);
        xacc(1, 16'h1800);
        chk("above lock", {flash_wr, flash_to_program}, 16'h3);
        chk("prog addr", flash_addr, 16'h1800);
        cfg(1'b1, 2'h0, 2'h2);
        xacc(1, 16'h0F00);
        chk("all lock", {access_denied, flash_wr}, 16'h2);
        dacc(1'b0, 1'b1, MMD_WSEL_ADDR, 8'h00);
        xacc(1, 16'h0400);
        chk("data free", {access_denied, flash_wr}, 16'h1);
        chk("data tgt", flash_to_program, 16'h0);
        dacc(1'b0, 1'b1, 8'h30, 8'h12);
        dacc(1'b0, 1'b0, 8'h30, 8'h00);
        chk("ram", dir_rdata, 16'h12);
        dacc(1'b0, 1'b0, 8'hA5, 8'h00);
        chk("undef sfr", dir_rdata, 16'h0);
        dacc(1'b0, 1'b0, 8'h90, 8'h00);
        chk("ext sfr", dir_rdata, 16'h5A);
        dacc(1'b0, 1'b1, MMD_STATUS_ADDR, 8'h18);
        chk("bank3", bank_q, 16'h3);
        dacc(1'b0, 1'b1, 8'h00, 8'h55, 1'b1, 3'h2);
        dacc(1'b0, 1'b1, MMD_STATUS_ADDR, 8'h00);
        dacc(1'b0, 1'b0, 8'h1A, 8'h00);
        chk("wreg", dir_rdata, 16'h55);
        dacc(1'b0, 1'b1, 8'h21, 8'h00);
        dacc(1'b0, 1'b1, 8'h0B, 8'hC3);
        dacc(1'b1, 1'b1, 8'h0B, 8'h01);
        dacc(1'b0, 1'b0, 8'h21, 8'h00);
        chk("ram bit", dir_rdata, 16'h08);
        dacc(1'b0, 1'b0, 8'h0B, 8'h00);
        chk("byte same addr", dir_rdata, 16'hC3);
        dacc(1'b1, 1'b0, 8'h0B, 8'h00);
        chk("bit rd", dir_rdata[0], 16'h1);
        dacc(1'b1, 1'b1, 8'hD3, 8'h01);
        chk("sfr bit", bank_q, 16'h1);
        test_done();
    end
endmodule
